// [include/cgspr_pkg.sv]
// constants for the clock generator serial port register bank
package cgspr_pkg;
   localparam int ADDR_W = 13;
   localparam int INSTR_W = 16;
   // register offsets
   localparam logic [12:0] OFS_SETUP = 13'h000;
   localparam logic [12:0] OFS_RSVD = 13'h002;
   localparam logic [12:0] OFS_DEV_ID = 13'h003;
   localparam logic [12:0] OFS_RB_SEL = 13'h004;
   localparam logic [12:0] OFS_VER_LO = 13'h005;
   localparam logic [12:0] OFS_VER_HI = 13'h006;
   localparam logic [12:0] OFS_PUMP = 13'h010;
   localparam logic [12:0] OFS_RDIV_LO = 13'h011;
   localparam logic [12:0] OFS_RDIV_HI = 13'h012;
   // values after reset
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_RB_SEL = 8'h00;
   localparam logic [7:0] RST_VER = 8'h00;
   localparam logic [7:0] RST_PUMP = 8'h7d;
   localparam logic [7:0] RST_RDIV_LO = 8'h01;
   localparam logic [5:0] RST_RDIV_HI = 6'h00;
   // serial setup field positions (each control mirrored in a bit pair)
   localparam int SDO_HI = 7;
   localparam int SDO_LO = 0;
   localparam int LSBF_HI = 6;
   localparam int LSBF_LO = 1;
   localparam int SRST_HI = 5;
   localparam int SRST_LO = 2;
   localparam int RDIV_HI_W = 6;
   // instruction word fields
   localparam int INS_RW = 15;
   localparam int INS_LEN_HI = 14;
   localparam int INS_LEN_LO = 13;
   localparam logic [1:0] LEN_STREAM = 2'h3;
   localparam logic [3:0] LAST_INSTR_BIT = 4'hf;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
endpackage : cgspr_pkg

// [rtl/cgspr_regs.sv]
// clock generator serial port register bank with staged and active copies
// Operation
// - writes to addresses outside the map change nothing.
// - writes to unused addresses or unused bits change nothing.
// - serial setup mirrors output enable, lsb first and soft reset in bit pairs; resets zero.
// - reference divider is 14 bits: low byte, then six bits at next address.
// - readback bit 0 set returns active bank, clear returns staged bank.
// - transfer strobe copies staged bank into active bank; only then values apply.
`timescale 1ns/10ps
module cgspr_regs #(
   parameter int          ADDR_W = 13,        // serial address width
   parameter logic [7:0]  DEVICE_ID = 8'h5a   // arbitrary identifier value
) (
   input  wire logic        clk,           // system clock
   input  wire logic        reset_n,       // async reset
   input  wire logic        sclk,          // serial clock from host
   input  wire logic        cs_n,          // frame select
   input  wire logic        sdio_i,        // data pin input
   output logic             sdio_o,        // data pin output
   output logic             sdio_oe,       // data pin drive enable
   output logic             sdo_o,         // separate output pin
   output logic             sdo_oe,        // separate output drive enable
   input  wire logic        update_strobe, // copy staged bank to active
   output logic [7:0]       pump_ctrl,     // active phase detector/pump control
   output logic [13:0]      ref_div,       // active reference divider
   output logic [15:0]      user_version   // active customer version
);
   // the decoder compares full 13-bit offsets, so no other width is served
   if (ADDR_W != cgspr_pkg::ADDR_W) begin : g_addr_w_check
      $error("cgspr_regs: ADDR_W must be 13");
   end

   logic [12:0] spi_addr;
   logic        wr_stb;
   logic [12:0] wr_addr;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data;
   logic        sdo_bit;
   logic        sdo_drive;
   logic        soft_req;
   logic        sdo_act_r;
   logic        lsbf_r;
   logic        rb_act_r;
   // staged bank
   logic [7:0]  b_ver_lo_r;
   logic [7:0]  b_ver_hi_r;
   logic [7:0]  b_pump_r;
   logic [7:0]  b_rdiv_lo_r;
   logic [5:0]  b_rdiv_hi_r;
   // active bank
   logic [7:0]  a_ver_lo_r;
   logic [7:0]  a_ver_hi_r;
   logic [7:0]  a_pump_r;
   logic [7:0]  a_rdiv_lo_r;
   logic [5:0]  a_rdiv_hi_r;

   cgspr_spi u_spi (
      .clk       (clk),
      .reset_n   (reset_n),
      .sclk      (sclk),
      .cs_n      (cs_n),
      .sdi       (sdio_i),
      .lsb_first (lsbf_r),
      .rd_data   (rd_data),
      .addr      (spi_addr),
      .wr_stb    (wr_stb),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .sdo_bit   (sdo_bit),
      .sdo_drive (sdo_drive)
   );

   // 4-wire mode moves read data to the separate pin
   assign sdio_o  = sdo_bit;
   assign sdo_o   = sdo_bit;
   assign sdio_oe = sdo_drive & ~sdo_act_r;
   assign sdo_oe  = sdo_drive & sdo_act_r;

   assign soft_req = wr_stb && wr_addr == cgspr_pkg::OFS_SETUP &&
                     (wr_data[cgspr_pkg::SRST_HI] | wr_data[cgspr_pkg::SRST_LO]);

   // serial setup takes effect at once, the reset bit is never stored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sdo_act_r <= cgspr_pkg::RST_SETUP[cgspr_pkg::SDO_LO];
         lsbf_r    <= cgspr_pkg::RST_SETUP[cgspr_pkg::LSBF_LO];
      end else if (soft_req) begin
         sdo_act_r <= cgspr_pkg::RST_SETUP[cgspr_pkg::SDO_LO];
         lsbf_r    <= cgspr_pkg::RST_SETUP[cgspr_pkg::LSBF_LO];
      end else if (wr_stb && wr_addr == cgspr_pkg::OFS_SETUP) begin
         sdo_act_r <= wr_data[cgspr_pkg::SDO_HI] | wr_data[cgspr_pkg::SDO_LO];
         lsbf_r    <= wr_data[cgspr_pkg::LSBF_HI] | wr_data[cgspr_pkg::LSBF_LO];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) rb_act_r <= cgspr_pkg::RST_RB_SEL[0];
      else if (soft_req) rb_act_r <= cgspr_pkg::RST_RB_SEL[0];
      else if (wr_stb && wr_addr == cgspr_pkg::OFS_RB_SEL) rb_act_r <= wr_data[0];
   end

   // staged bank: unmapped or unused targets fall through to default
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         b_ver_lo_r  <= cgspr_pkg::RST_VER;
         b_ver_hi_r  <= cgspr_pkg::RST_VER;
         b_pump_r    <= cgspr_pkg::RST_PUMP;
         b_rdiv_lo_r <= cgspr_pkg::RST_RDIV_LO;
         b_rdiv_hi_r <= cgspr_pkg::RST_RDIV_HI;
      end else if (soft_req) begin
         b_ver_lo_r  <= cgspr_pkg::RST_VER;
         b_ver_hi_r  <= cgspr_pkg::RST_VER;
         b_pump_r    <= cgspr_pkg::RST_PUMP;
         b_rdiv_lo_r <= cgspr_pkg::RST_RDIV_LO;
         b_rdiv_hi_r <= cgspr_pkg::RST_RDIV_HI;
      end else if (wr_stb) begin
         case (wr_addr)
            cgspr_pkg::OFS_VER_LO:  b_ver_lo_r  <= wr_data;
            cgspr_pkg::OFS_VER_HI:  b_ver_hi_r  <= wr_data;
            cgspr_pkg::OFS_PUMP:    b_pump_r    <= wr_data;
            cgspr_pkg::OFS_RDIV_LO: b_rdiv_lo_r <= wr_data;
            cgspr_pkg::OFS_RDIV_HI: b_rdiv_hi_r <= wr_data[cgspr_pkg::RDIV_HI_W-1:0];
            default: ;
         endcase
      end
   end

   // active bank changes only on the transfer strobe or a soft reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         a_ver_lo_r  <= cgspr_pkg::RST_VER;
         a_ver_hi_r  <= cgspr_pkg::RST_VER;
         a_pump_r    <= cgspr_pkg::RST_PUMP;
         a_rdiv_lo_r <= cgspr_pkg::RST_RDIV_LO;
         a_rdiv_hi_r <= cgspr_pkg::RST_RDIV_HI;
      end else if (soft_req) begin
         a_ver_lo_r  <= cgspr_pkg::RST_VER;
         a_ver_hi_r  <= cgspr_pkg::RST_VER;
         a_pump_r    <= cgspr_pkg::RST_PUMP;
         a_rdiv_lo_r <= cgspr_pkg::RST_RDIV_LO;
         a_rdiv_hi_r <= cgspr_pkg::RST_RDIV_HI;
      end else if (update_strobe) begin
         a_ver_lo_r  <= b_ver_lo_r;
         a_ver_hi_r  <= b_ver_hi_r;
         a_pump_r    <= b_pump_r;
         a_rdiv_lo_r <= b_rdiv_lo_r;
         a_rdiv_hi_r <= b_rdiv_hi_r;
      end
   end

   assign pump_ctrl    = a_pump_r;
   assign ref_div      = {a_rdiv_hi_r, a_rdiv_lo_r};
   assign user_version = {a_ver_hi_r, a_ver_lo_r};

   always_comb begin
      case (spi_addr)
         cgspr_pkg::OFS_SETUP:   rd_data = {sdo_act_r, lsbf_r, 4'h0, lsbf_r, sdo_act_r};
         cgspr_pkg::OFS_DEV_ID:  rd_data = DEVICE_ID;
         cgspr_pkg::OFS_RB_SEL:  rd_data = {7'h00, rb_act_r};
         cgspr_pkg::OFS_VER_LO:  rd_data = rb_act_r ? a_ver_lo_r : b_ver_lo_r;
         cgspr_pkg::OFS_VER_HI:  rd_data = rb_act_r ? a_ver_hi_r : b_ver_hi_r;
         cgspr_pkg::OFS_PUMP:    rd_data = rb_act_r ? a_pump_r : b_pump_r;
         cgspr_pkg::OFS_RDIV_LO: rd_data = rb_act_r ? a_rdiv_lo_r : b_rdiv_lo_r;
         cgspr_pkg::OFS_RDIV_HI: rd_data = {2'h0, rb_act_r ? a_rdiv_hi_r : b_rdiv_hi_r};
         default:                rd_data = 8'h00;
      endcase
   end

   // checks
   logic unmapped_wr;
   assign unmapped_wr = wr_stb && !(wr_addr inside {cgspr_pkg::OFS_SETUP, cgspr_pkg::OFS_RB_SEL,
      cgspr_pkg::OFS_VER_LO, cgspr_pkg::OFS_VER_HI, cgspr_pkg::OFS_PUMP, cgspr_pkg::OFS_RDIV_LO,
      cgspr_pkg::OFS_RDIV_HI});

   unmapped_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      unmapped_wr |=> $stable({b_ver_lo_r, b_ver_hi_r, b_pump_r, b_rdiv_lo_r, b_rdiv_hi_r,
                               sdo_act_r, lsbf_r, rb_act_r}))
      else $error("unmapped write changed state");

   // only the mirrored control pairs may leave a trace in the setup state
   unused_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && wr_addr == cgspr_pkg::OFS_SETUP && (wr_data & 8'hc3) == 8'h00)
      |=> !sdo_act_r && !lsbf_r)
      else $error("unused setup bits changed state");

   setup_mirror_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && wr_addr == cgspr_pkg::OFS_SETUP && !soft_req && wr_data[cgspr_pkg::SDO_HI])
      |=> sdo_act_r ##0 (spi_addr != cgspr_pkg::OFS_SETUP || (rd_data[7] && rd_data[0])))
      else $error("setup mirror bit not applied");

   ref_div_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && wr_addr == cgspr_pkg::OFS_RDIV_HI) |=> b_rdiv_hi_r == $past(wr_data[5:0]))
      else $error("divider high bits not staged");

   ref_low_stage_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && wr_addr == cgspr_pkg::OFS_RDIV_LO) |=> b_rdiv_lo_r == $past(wr_data))
      else $error("divider low byte not staged");

   rb_select_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && wr_addr == cgspr_pkg::OFS_RB_SEL) |=> rb_act_r == $past(wr_data[0]))
      else $error("readback select bit not taken");

   ver_stage_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && wr_addr == cgspr_pkg::OFS_VER_LO) |=> b_ver_lo_r == $past(wr_data))
      else $error("version low byte not staged");

   readback_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      (spi_addr == cgspr_pkg::OFS_PUMP) |-> rd_data == (rb_act_r ? a_pump_r : b_pump_r))
      else $error("readback bank select wrong");

   transfer_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
      (update_strobe && !soft_req) |=> {pump_ctrl, ref_div} == $past({b_pump_r, b_rdiv_hi_r, b_rdiv_lo_r}))
      else $error("transfer did not copy staged bank");

   active_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!update_strobe && !soft_req) |=> $stable({pump_ctrl, ref_div, user_version}))
      else $error("active bank changed without transfer");

   // soft reset outranks both a coincident write and the transfer strobe
   soft_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
      soft_req |=> (b_pump_r == cgspr_pkg::RST_PUMP && a_rdiv_lo_r == cgspr_pkg::RST_RDIV_LO &&
                    !sdo_act_r && !lsbf_r && !rb_act_r) [*2])
      else $error("soft reset did not restore defaults");
endmodule : cgspr_regs

// [rtl/cgspr_spi.sv]
// serial port framing: instruction decode, data bytes, read bit output
`timescale 1ns/10ps
module cgspr_spi (
   input  wire logic        clk,        // system clock
   input  wire logic        reset_n,    // async reset
   input  wire logic        sclk,       // serial clock from host
   input  wire logic        cs_n,       // frame select
   input  wire logic        sdi,        // serial data in
   input  wire logic        lsb_first,  // bit order and address step
   input  wire logic [7:0]  rd_data,    // read data for addr
   output logic [12:0]      addr,       // current byte address
   output logic             wr_stb,     // write byte pulse
   output logic [12:0]      wr_addr,    // write address
   output logic [7:0]       wr_data,    // write data
   output logic             sdo_bit,    // read bit
   output logic             sdo_drive   // read phase active
);
   typedef enum logic [2:0] {S_INSTR = 3'b001, S_DATA = 3'b010, S_HOLD = 3'b100} cgspr_state_t;
   cgspr_state_t state_r;
   logic        sclk_d_r;
   logic [3:0]  bitcnt_r;
   logic [15:0] sr_r;
   logic [15:0] sr_nxt;
   logic        read_r;
   logic        stream_r;
   logic [1:0]  left_r;
   logic [12:0] addr_r;
   logic [7:0]  tx_r;
   logic        rise;
   logic        fall;
   logic        byte_end;

   function automatic logic pick(input logic [7:0] b, input logic [3:0] i, input logic lsb);
      pick = lsb ? b[i[2:0]] : b[3'h7 - i[2:0]];
   endfunction : pick

   assign rise = sclk & ~sclk_d_r & ~cs_n;
   assign fall = ~sclk & sclk_d_r & ~cs_n;
   assign sr_nxt = lsb_first ? {sdi, sr_r[15:1]} : {sr_r[14:0], sdi};
   assign byte_end = rise && (state_r == S_DATA) && (bitcnt_r == cgspr_pkg::LAST_DATA_BIT);
   assign addr = addr_r;
   assign sdo_drive = ~cs_n & (state_r == S_DATA) & read_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) sclk_d_r <= 1'b0;
      else sclk_d_r <= sclk;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r  <= S_INSTR;
         bitcnt_r <= 4'h0;
         sr_r     <= 16'h0000;
         read_r   <= 1'b0;
         stream_r <= 1'b0;
         left_r   <= 2'h0;
         addr_r   <= 13'h0000;
      end else if (cs_n) begin
         // a partial byte at frame end is dropped
         state_r  <= S_INSTR;
         bitcnt_r <= 4'h0;
      end else if (rise) begin
         sr_r <= sr_nxt;
         case (state_r)
            S_INSTR: begin
               if (bitcnt_r == cgspr_pkg::LAST_INSTR_BIT) begin
                  read_r   <= sr_nxt[cgspr_pkg::INS_RW];
                  left_r   <= sr_nxt[cgspr_pkg::INS_LEN_HI:cgspr_pkg::INS_LEN_LO];
                  stream_r <= sr_nxt[cgspr_pkg::INS_LEN_HI:cgspr_pkg::INS_LEN_LO] == cgspr_pkg::LEN_STREAM;
                  addr_r   <= sr_nxt[12:0];
                  bitcnt_r <= 4'h0;
                  state_r  <= S_DATA;
               end else bitcnt_r <= bitcnt_r + 4'h1;
            end
            S_DATA: begin
               if (bitcnt_r == cgspr_pkg::LAST_DATA_BIT) begin
                  bitcnt_r <= 4'h0;
                  addr_r   <= lsb_first ? addr_r + 13'h0001 : addr_r - 13'h0001;
                  if (!stream_r && left_r == 2'h0) state_r <= S_HOLD;
                  else if (!stream_r) left_r <= left_r - 2'h1;
               end else bitcnt_r <= bitcnt_r + 4'h1;
            end
            S_HOLD: ;
            default: state_r <= S_INSTR;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_stb  <= 1'b0;
         wr_addr <= 13'h0000;
         wr_data <= 8'h00;
      end else begin
         wr_stb <= byte_end && !read_r;
         if (byte_end && !read_r) begin
            wr_addr <= addr_r;
            wr_data <= lsb_first ? sr_nxt[15:8] : sr_nxt[7:0];
         end
      end
   end

   // read bits change on the falling edge so the host samples on the rising one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_r    <= 8'h00;
         sdo_bit <= 1'b0;
      end else if (fall && sdo_drive) begin
         if (bitcnt_r == 4'h0) begin
            tx_r    <= rd_data;
            sdo_bit <= pick(rd_data, 4'h0, lsb_first);
         end else sdo_bit <= pick(tx_r, bitcnt_r, lsb_first);
      end
   end
endmodule : cgspr_spi

// [tb/cgspr_host.sv]
// serial host model that frames one-byte transfers and two-byte write bursts into the register bank
`timescale 1ns/10ps
module cgspr_host (
   input  wire logic clk,       // system clock
   input  wire logic sdio_line, // resolved two-way data wire
   input  wire logic sdo_line,  // resolved separate output wire
   output logic      sclk,      // serial clock, still outside frames
   output logic      cs_n,      // frame select
   output logic      sdi        // host drive on the data wire
);
   logic lsb_mode = 1'b0;
   logic four_wire = 1'b0;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // four clocks per half period keeps sclk well below clk/2
   task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] rdv);
      logic [15:0] ins;
      ins = {rd, 2'h0, a};
      rdv = 8'h00;
      cs_n = 1'b0;
      step(4);
      for (int i = 0; i < 24; i++) begin
         sclk = 1'b0;
         if (i < 16)
            sdi = ins[lsb_mode ? i : 15 - i];
         else if (rd)
            sdi = ~sdi;
         else
            sdi = wd[lsb_mode ? i - 16 : 23 - i];
         step(4);
         if (rd && i >= 16)
            rdv[lsb_mode ? i - 16 : 23 - i] = four_wire ? sdo_line : sdio_line;
         sclk = 1'b1;
         step(4);
      end
      sclk = 1'b0;
      step(4);
      cs_n = 1'b1;
      // released line must not keep its last value
      sdi = ~sdi;
      step(4);
   endtask : xfer

   // two-byte write, msb first only; len 1 counts the bytes, len 3 streams, len 0 drops the second
   task automatic burst(input logic [1:0] len, input logic [12:0] a, input logic [15:0] wd);
      logic [31:0] bits;
      bits = {1'b0, len, a, wd};
      cs_n = 1'b0;
      step(4);
      for (int i = 0; i < 32; i++) begin
         sclk = 1'b0;
         sdi = bits[31 - i];
         step(4);
         sclk = 1'b1;
         step(4);
      end
      sclk = 1'b0;
      step(4);
      cs_n = 1'b1;
      sdi = ~sdi;
      step(4);
   endtask : burst
endmodule : cgspr_host

// [tb/tb.sv]
// self-checking bench for the serial port register bank
`timescale 1ns/10ps
module tb;
   localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identifier value
   logic        clk;
   logic        reset_n;
   logic        sclk;
   logic        cs_n;
   logic        host_sdi;
   logic        sdio_i;
   logic        sdio_o;
   logic        sdio_oe;
   logic        sdo_o;
   logic        sdo_oe;
   logic        sdo_line;
   logic        update_strobe;
   logic [7:0]  pump_ctrl;
   logic [13:0] ref_div;
   logic [15:0] user_version;
   int          error_cnt = 0;
   int          samples_checked = 0;
   logic [12:0] holes [6] = '{13'h001, 13'h002, 13'h007, 13'h00f, 13'h100, 13'h1fff};

   assign sdio_i = sdio_oe ? sdio_o : host_sdi;
   assign sdo_line = sdo_oe ? sdo_o : ~sdo_o;

   cgspr_regs #(.ADDR_W(cgspr_pkg::ADDR_W), .DEVICE_ID(ID_VAL)) u_dut (
      .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
      .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .update_strobe(update_strobe),
      .pump_ctrl(pump_ctrl), .ref_div(ref_div), .user_version(user_version));

   cgspr_host u_host (.clk(clk), .sdio_line(sdio_i), .sdo_line(sdo_line), .sclk(sclk), .cs_n(cs_n), .sdi(host_sdi));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] unused_v;
      u_host.xfer(1'b0, a, d, unused_v);
   endtask : wr

   task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
      logic [7:0] v;
      u_host.xfer(1'b1, a, 8'h00, v);
      check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, v});
   endtask : rd_chk

   task automatic strobe();
      update_strobe = 1'b1;
      u_host.step(1);
      update_strobe = 1'b0;
      u_host.step(1);
   endtask : strobe

   task automatic outs(input logic [7:0] p, input logic [13:0] r, input logic [15:0] v);
      check("pump_ctrl", {8'h00, p}, {8'h00, pump_ctrl});
      check("ref_div", {2'h0, r}, {2'h0, ref_div});
      check("user_version", v, user_version);
   endtask : outs

   task automatic print_verdict();
      if (error_cnt == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      $display("mismatch run_length expected %h seen %h", 1'b0, 1'b1);
      print_verdict();
   end

   initial begin
      reset_n = 1'b0;
      update_strobe = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      reset_n = 1'b1;
      u_host.step(1);
      outs(8'h7d, 14'h0001, 16'h0000);
      rd_chk(cgspr_pkg::OFS_SETUP, 8'h00);
      rd_chk(cgspr_pkg::OFS_RB_SEL, 8'h00);
      wr(cgspr_pkg::OFS_DEV_ID, 8'hff);
      rd_chk(cgspr_pkg::OFS_DEV_ID, ID_VAL);
      // staged values stay hidden from the active outputs until the strobe
      wr(cgspr_pkg::OFS_PUMP, 8'ha5);
      wr(cgspr_pkg::OFS_RDIV_LO, 8'h34);
      wr(cgspr_pkg::OFS_RDIV_HI, 8'hff);
      wr(cgspr_pkg::OFS_VER_LO, 8'h12);
      wr(cgspr_pkg::OFS_VER_HI, 8'h34);
      outs(8'h7d, 14'h0001, 16'h0000);
      rd_chk(cgspr_pkg::OFS_PUMP, 8'ha5);
      rd_chk(cgspr_pkg::OFS_RDIV_HI, 8'h3f);
      wr(cgspr_pkg::OFS_RB_SEL, 8'hff);
      rd_chk(cgspr_pkg::OFS_RB_SEL, 8'h01);
      rd_chk(cgspr_pkg::OFS_PUMP, 8'h7d);
      strobe();
      outs(8'ha5, 14'h3f34, 16'h3412);
      rd_chk(cgspr_pkg::OFS_PUMP, 8'ha5);
      rd_chk(cgspr_pkg::OFS_RDIV_LO, 8'h34);
      for (int i = 0; i < 6; i++) begin
         wr(holes[i], 8'hff);
         rd_chk(holes[i], 8'h00);
      end
      strobe();
      outs(8'ha5, 14'h3f34, 16'h3412);
      // separate output pin, then reversed bit order on single-byte transfers
      wr(cgspr_pkg::OFS_SETUP, 8'h81);
      u_host.four_wire = 1'b1;
      rd_chk(cgspr_pkg::OFS_SETUP, 8'h81);
      wr(cgspr_pkg::OFS_SETUP, 8'hc3);
      u_host.lsb_mode = 1'b1;
      rd_chk(cgspr_pkg::OFS_SETUP, 8'hc3);
      rd_chk(cgspr_pkg::OFS_RDIV_LO, 8'h34);
      wr(cgspr_pkg::OFS_VER_LO, 8'h56);
      strobe();
      outs(8'ha5, 14'h3f34, 16'h3456);
      wr(cgspr_pkg::OFS_SETUP, 8'h24);
      u_host.lsb_mode = 1'b0;
      u_host.four_wire = 1'b0;
      outs(8'h7d, 14'h0001, 16'h0000);
      rd_chk(cgspr_pkg::OFS_SETUP, 8'h00);
      rd_chk(cgspr_pkg::OFS_RB_SEL, 8'h00);
      rd_chk(cgspr_pkg::OFS_PUMP, 8'h7d);
      wr(cgspr_pkg::OFS_SETUP, 8'h18);
      rd_chk(cgspr_pkg::OFS_SETUP, 8'h00);
      // bursts step the address down; bytes past the count are dropped
      u_host.burst(2'h1, cgspr_pkg::OFS_VER_HI, 16'h9abc);
      rd_chk(cgspr_pkg::OFS_VER_HI, 8'h9a);
      rd_chk(cgspr_pkg::OFS_VER_LO, 8'hbc);
      u_host.burst(2'h3, cgspr_pkg::OFS_RDIV_HI, 16'h4756);
      u_host.burst(2'h0, cgspr_pkg::OFS_VER_LO, 16'h7701);
      rd_chk(cgspr_pkg::OFS_VER_LO, 8'h77);
      rd_chk(cgspr_pkg::OFS_RB_SEL, 8'h00);
      rd_chk(cgspr_pkg::OFS_RDIV_HI, 8'h07);
      rd_chk(cgspr_pkg::OFS_RDIV_LO, 8'h56);
      outs(8'h7d, 14'h0001, 16'h0000);
      strobe();
      outs(8'h7d, 14'h0756, 16'h9a77);
      print_verdict();
   end
endmodule : tb
